// ---- hdl/io_map_pkg.sv ----
// Package with the I/O image map, function codes and exception codes of the query decoder.
package io_map_pkg;
	localparam logic [7:0] fc_read_coils = 8'h01;
	localparam logic [7:0] fc_read_inputs = 8'h02;
	localparam logic [7:0] fc_read_holding = 8'h03;
	localparam logic [7:0] fc_read_analog_in = 8'h04;
	localparam logic [7:0] fc_write_coil = 8'h05;
	localparam logic [7:0] fc_write_holding = 8'h06;
	localparam logic [7:0] fc_write_coils = 8'h0f;
	localparam logic [7:0] exc_bad_function = 8'h01;
	localparam logic [7:0] exc_bad_address = 8'h02;
	localparam logic [7:0] exc_bad_value = 8'h03;
	localparam int slot_size = 16;
	localparam int slot_count = 7;
	localparam int area_size = slot_size * slot_count;
	localparam logic [15:0] area_last = 16'h006f;
	localparam logic [3:0] analog_out_slots = 4'h8;
	localparam logic [3:0] base_counter_regs = 4'h7;
	localparam logic [3:0] exp_counter_regs = 4'h2;
	localparam logic [3:0] base_freq_lo = 4'h8;
	localparam logic [3:0] base_freq_hi = 4'h9;
	localparam logic [3:0] exp_freq_lo = 4'h8;
	localparam logic [3:0] exp_freq_hi = 4'h9;
	localparam logic [15:0] count_max = 16'h270f;
	localparam logic [15:0] coil_on = 16'hff00;
	localparam logic [15:0] coil_off = 16'h0000;
	localparam logic [7:0] fw_coil_write_min = 8'h20;
endpackage : io_map_pkg

// ---- hdl/pulse_accumulator.sv ----
// Two-register decimal accumulator, each register spanning 0 to 9999.
`timescale 1ns/1ps
`default_nettype none
module pulse_accumulator (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic count_pulse,
	input wire logic load_lo,
	input wire logic load_hi,
	input wire logic [15:0] load_value,
	output logic [15:0] count_lo,
	output logic [15:0] count_hi
);
	logic [15:0] lo_q, lo_d, hi_q, hi_d;

	always_comb begin
		lo_d = lo_q;
		hi_d = hi_q;
		if (load_lo) begin
			lo_d = load_value;
		end else if (count_pulse) begin
			if (lo_q >= io_map_pkg::count_max) begin
				lo_d = 16'h0000;
				hi_d = (hi_q >= io_map_pkg::count_max) ? 16'h0000 : hi_q + 16'h0001;
			end else begin
				lo_d = lo_q + 16'h0001;
			end
		end
		if (load_hi) begin
			hi_d = load_value;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lo_q <= 16'h0000;
			hi_q <= 16'h0000;
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
		end
	end

	assign count_lo = lo_q;
	assign count_hi = hi_q;

	wrap_carry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(count_pulse && !load_lo && !load_hi && lo_q == io_map_pkg::count_max && hi_q < io_map_pkg::count_max)
		|=> (lo_q == 16'h0000 && hi_q == $past(hi_q) + 16'h0001)) else $error("accumulator carry wrong");
	lo_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!$past(load_lo) && $past(lo_q) <= io_map_pkg::count_max) |-> lo_q <= io_map_pkg::count_max)
		else $error("low count left its range");
endmodule // pulse_accumulator
`default_nettype wire

// ---- hdl/modbus_io_address_decoder.sv ----
// Query decoder mapping function codes and implied addresses onto the I/O image.
`timescale 1ns/1ps
`default_nettype none
module modbus_io_address_decoder (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic query_valid,
	input wire logic [7:0] query_function,
	input wire logic [15:0] query_start,
	input wire logic [15:0] query_count,
	input wire logic [111:0] query_coil_data,
	input wire logic [15:0] query_reg_data,
	input wire logic [7:0] firmware_revision,
	input wire logic [6:0] unit_fitted,
	input wire logic [111:0] coil_present,
	input wire logic [111:0] input_present,
	input wire logic [111:0] analog_in_present,
	input wire logic [111:0] analog_out_present,
	input wire logic [111:0] input_contact_bit,
	input wire logic [111:0] analog_input_flat,
	input wire logic [15:0] freq_ch0,
	input wire logic [15:0] freq_ch1,
	input wire logic [1:0] count_pulse,
	output logic reply_valid,
	output logic reply_exception,
	output logic [7:0] reply_function,
	output logic [7:0] reply_exc_code,
	output logic [111:0] reply_bits,
	output logic [15:0] reply_reg,
	output logic [111:0] coil_out,
	output logic [15:0] analog_output_register [0:111]
);
	typedef enum logic [1:0] {st_idle, st_check, st_exec} state_t;
	state_t state_q, state_d;
	logic [7:0] fn_q, fn_d;
	logic [15:0] start_q, start_d, cnt_q, cnt_d, wval_q, wval_d;
	logic [111:0] wbits_q, wbits_d;
	logic [111:0] coil_q, coil_d, in_img_q, in_img_d;
	logic [15:0] ao_q [0:111];
	logic [15:0] ao_d [0:111];
	logic [15:0] ai_img_q [0:111];
	logic rv_q, rv_d, rx_q, rx_d;
	logic [7:0] rf_q, rf_d, rc_q, rc_d;
	logic [111:0] rb_q, rb_d;
	logic [15:0] rr_q, rr_d;
	logic [16:0] last_addr;
	logic range_ok, impl_ok, writable;
	logic [2:0] slot;
	logic [3:0] offs;
	logic [1:0] acc_lo_load, acc_hi_load;
	logic [15:0] acc_lo [0:1];
	logic [15:0] acc_hi [0:1];
	logic [111:0] present;
	logic fn_known;

	// Inputs are sampled into the image every cycle so reads never see a half-updated pin.
	genvar g;
	generate
		for (g = 0; g < io_map_pkg::area_size; g++) begin : g_img
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					ai_img_q[g] <= 16'h0000;
				end else begin
					ai_img_q[g] <= {15'h0000, analog_input_flat[g]};
				end
			end
		end
		for (g = 0; g < 2; g++) begin : g_acc
			pulse_accumulator u_acc (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.count_pulse(count_pulse[g]),
				.load_lo(acc_lo_load[g]),
				.load_hi(acc_hi_load[g]),
				.load_value(wval_q),
				.count_lo(acc_lo[g]),
				.count_hi(acc_hi[g])
			);
		end
	endgenerate

	// Decode for the single-address checks uses the start address.
	always_comb begin
		slot = start_q[6:4];
		offs = start_q[3:0];
		last_addr = {1'b0, start_q} + {1'b0, cnt_q} - 17'h00001;
		range_ok = (cnt_q != 16'h0000) && (last_addr <= {1'b0, io_map_pkg::area_last});
		case (fn_q)
			io_map_pkg::fc_read_coils, io_map_pkg::fc_write_coil, io_map_pkg::fc_write_coils: present = coil_present;
			io_map_pkg::fc_read_inputs: present = input_present;
			io_map_pkg::fc_read_analog_in: present = analog_in_present;
			default: present = analog_out_present;
		endcase
		impl_ok = range_ok && unit_fitted[slot] && present[start_q[6:0]];
		if (fn_q == io_map_pkg::fc_write_holding && slot == 3'h0) begin
			writable = offs < io_map_pkg::analog_out_slots ? present[start_q[6:0]]
				: (offs < io_map_pkg::analog_out_slots + io_map_pkg::base_counter_regs)
				&& offs != io_map_pkg::base_freq_lo && offs != io_map_pkg::base_freq_hi;
		end else if (fn_q == io_map_pkg::fc_write_holding) begin
			writable = offs < io_map_pkg::analog_out_slots;
		end else begin
			writable = 1'b1;
		end
		fn_known = fn_q == io_map_pkg::fc_read_coils || fn_q == io_map_pkg::fc_read_inputs
			|| fn_q == io_map_pkg::fc_read_holding || fn_q == io_map_pkg::fc_read_analog_in
			|| fn_q == io_map_pkg::fc_write_holding || fn_q == io_map_pkg::fc_write_coils
			|| (fn_q == io_map_pkg::fc_write_coil && firmware_revision >= io_map_pkg::fw_coil_write_min);
	end

	always_comb begin
		state_d = state_q;
		fn_d = fn_q;
		start_d = start_q;
		cnt_d = cnt_q;
		wval_d = wval_q;
		wbits_d = wbits_q;
		coil_d = coil_q;
		in_img_d = input_contact_bit;
		ao_d = ao_q;
		rv_d = 1'b0;
		rx_d = rx_q;
		rf_d = rf_q;
		rc_d = rc_q;
		rb_d = rb_q;
		rr_d = rr_q;
		acc_lo_load = 2'b00;
		acc_hi_load = 2'b00;
		case (state_q)
			st_idle: begin
				if (query_valid) begin
					fn_d = query_function;
					start_d = query_start;
					cnt_d = (query_function == io_map_pkg::fc_write_coil
						|| query_function == io_map_pkg::fc_write_holding) ? 16'h0001 : query_count;
					wval_d = query_reg_data;
					wbits_d = query_coil_data;
					state_d = st_check;
				end
			end
			st_check: begin
				rf_d = fn_q;
				rb_d = '0;
				rr_d = 16'h0000;
				rx_d = 1'b1;
				state_d = st_idle;
				rv_d = 1'b1;
				if (!fn_known) begin
					rc_d = io_map_pkg::exc_bad_function;
				end else if (!impl_ok || !writable) begin
					rc_d = io_map_pkg::exc_bad_address;
				end else if (fn_q == io_map_pkg::fc_write_coil && wval_q != io_map_pkg::coil_on
					&& wval_q != io_map_pkg::coil_off) begin
					rc_d = io_map_pkg::exc_bad_value;
				end else begin
					rx_d = 1'b0;
					rc_d = 8'h00;
					rv_d = 1'b0;
					state_d = st_exec;
				end
			end
			default: begin
				rv_d = 1'b1;
				state_d = st_idle;
				for (int i = 0; i < io_map_pkg::area_size; i++) begin
					if (i >= start_q && i <= last_addr) begin
						case (fn_q)
							io_map_pkg::fc_read_coils: rb_d[i - start_q] = coil_q[i];
							io_map_pkg::fc_read_inputs: rb_d[i - start_q] = in_img_q[i];
							io_map_pkg::fc_write_coils: coil_d[i] = wbits_q[i - start_q];
							default: ;
						endcase
					end
				end
				if (fn_q == io_map_pkg::fc_write_coil) begin
					coil_d[start_q[6:0]] = (wval_q == io_map_pkg::coil_on);
				end
				if (fn_q == io_map_pkg::fc_read_analog_in) begin
					rr_d = ai_img_q[start_q[6:0]];
				end
				if (fn_q == io_map_pkg::fc_read_holding) begin
					rr_d = ao_q[start_q[6:0]];
					if (slot == 3'h0 && offs == io_map_pkg::base_freq_lo) rr_d = freq_ch0;
					if (slot == 3'h0 && offs == io_map_pkg::base_freq_hi) rr_d = freq_ch1;
					// Offset bit 2 picks the counter: 10 and 11 belong to the first, 12 and 13 to the second.
					if (slot == 3'h0 && offs >= 4'ha && offs <= 4'hd) begin
						rr_d = offs[0] ? acc_lo[offs[2]] : acc_hi[offs[2]];
					end
					if (slot == 3'h0 && offs == 4'he) rr_d = 16'h0000;
				end
				if (fn_q == io_map_pkg::fc_write_holding) begin
					if (offs < io_map_pkg::analog_out_slots) begin
						ao_d[start_q[6:0]] = wval_q;
					end else if (slot == 3'h0 && offs >= 4'ha && offs <= 4'hd) begin
						acc_lo_load[offs[2]] = offs[0];
						acc_hi_load[offs[2]] = !offs[0];
					end
					rr_d = wval_q;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= st_idle;
			fn_q <= 8'h00;
			start_q <= 16'h0000;
			cnt_q <= 16'h0000;
			wval_q <= 16'h0000;
			wbits_q <= '0;
			coil_q <= '0;
			in_img_q <= '0;
			for (int i = 0; i < io_map_pkg::area_size; i++) ao_q[i] <= 16'h0000;
			rv_q <= 1'b0;
			rx_q <= 1'b0;
			rf_q <= 8'h00;
			rc_q <= 8'h00;
			rb_q <= '0;
			rr_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			fn_q <= fn_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
			wval_q <= wval_d;
			wbits_q <= wbits_d;
			coil_q <= coil_d;
			in_img_q <= in_img_d;
			ao_q <= ao_d;
			rv_q <= rv_d;
			rx_q <= rx_d;
			rf_q <= rf_d;
			rc_q <= rc_d;
			rb_q <= rb_d;
			rr_q <= rr_d;
		end
	end

	assign reply_valid = rv_q;
	assign reply_exception = rx_q;
	assign reply_function = rf_q;
	assign reply_exc_code = rc_q;
	assign reply_bits = rb_q;
	assign reply_reg = rr_q;
	assign coil_out = coil_q;
	assign analog_output_register = ao_q;

	bad_fn_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_check && !fn_known) |=> (reply_valid && reply_exception
		&& reply_exc_code == io_map_pkg::exc_bad_function && $stable(coil_out))) else $error("bad code not refused");
	bad_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_check && fn_known && !range_ok) |=> reply_valid && reply_exception) else $error("range not refused");
	coil_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_exec && fn_q == io_map_pkg::fc_write_coil && wval_q == io_map_pkg::coil_on)
		|=> coil_out[$past(start_q[6:0])]) else $error("coil not driven on");
	one_reply_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_idle && query_valid) |-> ##[2:3] reply_valid) else $error("query got no reply");
	freq_ro_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_check && fn_q == io_map_pkg::fc_write_holding && start_q == 16'h0008)
		|=> reply_exception) else $error("frequency write accepted");
	coil5_fw_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == st_check && fn_q == io_map_pkg::fc_write_coil && firmware_revision < io_map_pkg::fw_coil_write_min)
		|=> reply_exception) else $error("coil write on old firmware");
endmodule // modbus_io_address_decoder
`default_nettype wire

// ---- verification/query_master.sv ----
// Master model that issues one query at a time and waits for its reply.
`timescale 1ns/1ps
`default_nettype none
module query_master (
	input wire logic ref_clk,
	input wire logic reply_valid,
	output logic query_valid,
	output logic [7:0] query_function,
	output logic [15:0] query_start,
	output logic [15:0] query_count,
	output logic [111:0] query_coil_data,
	output logic [15:0] query_reg_data,
	output logic timed_out
);
	initial begin
		query_valid = 1'b0;
		query_function = 8'h00;
		query_start = 16'h0000;
		query_count = 16'h0000;
		query_coil_data = '0;
		query_reg_data = 16'h0000;
		timed_out = 1'b0;
	end
	// Addresses go out implied, as offsets inside the area.
	task automatic send(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] cnt,
		input logic [111:0] cd, input logic [15:0] v);
		int n;
		@(negedge ref_clk);
		query_valid = 1'b1;
		query_function = fn;
		query_start = st;
		query_count = cnt;
		query_coil_data = cd;
		query_reg_data = v;
		@(negedge ref_clk);
		query_valid = 1'b0;
		// Released fields are inverted so that a late sample cannot pass by luck.
		query_function = ~fn;
		query_start = ~st;
		query_count = ~cnt;
		query_coil_data = ~cd;
		query_reg_data = ~v;
		n = 0;
		while (reply_valid !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		timed_out = (reply_valid !== 1'b1);
	endtask
endmodule // query_master
`default_nettype wire

// ---- verification/modbus_io_address_decoder_tb.sv ----
// Self-checking bench for the query decoder.
`timescale 1ns/1ps
`default_nettype none
module modbus_io_address_decoder_tb;
	logic ref_clk, nrst, query_valid, timed_out, reply_valid, reply_exception;
	logic [7:0] query_function, firmware_revision, reply_function, reply_exc_code;
	logic [15:0] query_start, query_count, query_reg_data, freq_ch0, freq_ch1, reply_reg;
	logic [111:0] query_coil_data, coil_present, input_present, analog_in_present, analog_out_present;
	logic [111:0] input_contact_bit, analog_input_flat, reply_bits, coil_out, m_coils;
	logic [6:0] unit_fitted;
	logic [1:0] count_pulse;
	logic [15:0] ao [0:111];
	int miscompares, comparisons;
	query_master query_master_i (.ref_clk(ref_clk), .reply_valid(reply_valid), .query_valid(query_valid),
		.query_function(query_function), .query_start(query_start), .query_count(query_count),
		.query_coil_data(query_coil_data), .query_reg_data(query_reg_data), .timed_out(timed_out));
	modbus_io_address_decoder modbus_io_address_decoder_i (.ref_clk(ref_clk), .nrst(nrst),
		.query_valid(query_valid), .query_function(query_function), .query_start(query_start),
		.query_count(query_count), .query_coil_data(query_coil_data), .query_reg_data(query_reg_data),
		.firmware_revision(firmware_revision), .unit_fitted(unit_fitted), .coil_present(coil_present),
		.input_present(input_present), .analog_in_present(analog_in_present),
		.analog_out_present(analog_out_present), .input_contact_bit(input_contact_bit),
		.analog_input_flat(analog_input_flat), .freq_ch0(freq_ch0), .freq_ch1(freq_ch1),
		.count_pulse(count_pulse), .reply_valid(reply_valid), .reply_exception(reply_exception),
		.reply_function(reply_function), .reply_exc_code(reply_exc_code), .reply_bits(reply_bits),
		.reply_reg(reply_reg), .coil_out(coil_out), .analog_output_register(ao));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [111:0] seen, input logic [111:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic q(input logic [7:0] fn, input int st, input logic [15:0] cnt, input logic [111:0] cd,
		input logic [15:0] v);
		query_master_i.send(fn, 16'(st), cnt, cd, v);
		check(reply_function, fn);
		if (timed_out) begin
			miscompares++;
			stop_test();
		end
	endtask
	// An exception reply carries the expected code and leaves the coil image alone.
	task automatic exc(input logic [7:0] code);
		check(reply_exception, 1'b1);
		check(reply_exc_code, code);
		check(coil_out, m_coils);
	endtask
	initial begin
		int a;
		logic [127:0] w;
		logic [15:0] v;
		logic [7:0] bad_fn [3];
		miscompares = 0;
		comparisons = 0;
		bad_fn = '{8'h00, 8'h07, 8'h10};
		nrst = 1'b0;
		firmware_revision = 8'h20;
		unit_fitted = 7'h7f;
		coil_present = '1;
		input_present = '1;
		analog_in_present = '1;
		analog_out_present = '1;
		input_contact_bit = '0;
		analog_input_flat = '0;
		freq_ch0 = 16'h0000;
		freq_ch1 = 16'h0000;
		count_pulse = 2'b00;
		m_coils = '0;
		void'($urandom(32'hf39805ad));
		repeat (8) @(negedge ref_clk);
		nrst = 1'b1;
		for (int i = 0; i < 5; i++) begin
			a = (i == 4) ? 111 : $urandom_range(110);
			q(io_map_pkg::fc_write_coil, a, 16'h0001, '0, io_map_pkg::coil_on);
			m_coils[a] = 1'b1;
			check(coil_out, m_coils);
		end
		w = {$urandom, $urandom, $urandom, $urandom};
		q(io_map_pkg::fc_write_coils, 0, 16'h0070, w[111:0], 16'h0000);
		m_coils = w[111:0];
		check(coil_out, m_coils);
		q(io_map_pkg::fc_read_coils, 0, 16'h0070, '0, 16'h0000);
		check(reply_bits, m_coils);
		$display("coil test done");
		unit_fitted = 7'h7d;
		q(io_map_pkg::fc_write_coil, 16, 16'h0001, '0, io_map_pkg::coil_on);
		exc(io_map_pkg::exc_bad_address);
		q(io_map_pkg::fc_write_coil, 15, 16'h0001, '0, io_map_pkg::coil_off);
		m_coils[15] = 1'b0;
		check(coil_out, m_coils);
		unit_fitted = 7'h7f;
		firmware_revision = 8'h1f;
		q(io_map_pkg::fc_write_coil, 3, 16'h0001, '0, ~{15'h0000, m_coils[3]} & io_map_pkg::coil_on);
		check(reply_exception, 1'b1);
		check(reply_exc_code, io_map_pkg::exc_bad_function);
		check(coil_out, m_coils);
		firmware_revision = 8'h20;
		q(io_map_pkg::fc_write_coil, 2, 16'h0001, '0, 16'h1234);
		exc(io_map_pkg::exc_bad_value);
		$display("slot and firmware test done");
		w = {$urandom, $urandom, $urandom, $urandom};
		input_contact_bit = w[111:0];
		w = {$urandom, $urandom, $urandom, $urandom};
		analog_input_flat = w[111:0];
		repeat (2) @(negedge ref_clk);
		q(io_map_pkg::fc_read_inputs, 0, 16'h0070, '0, 16'h0000);
		check(reply_bits, input_contact_bit);
		a = $urandom_range(111);
		q(io_map_pkg::fc_read_analog_in, a, 16'h0001, '0, 16'h0000);
		check(reply_reg, {15'h0000, analog_input_flat[a]});
		$display("input test done");
		for (int i = 0; i < 8; i++) begin
			a = 16 * $urandom_range(6) + i;
			v = 16'($urandom);
			q(io_map_pkg::fc_write_holding, a, 16'h0001, '0, v);
			check(reply_reg, v);
			check(reply_exception, 1'b0);
			check(ao[a], v);
			q(io_map_pkg::fc_read_holding, a, 16'h0001, '0, 16'h0000);
			check(reply_reg, v);
		end
		freq_ch0 = 16'($urandom);
		q(io_map_pkg::fc_read_holding, 8, 16'h0001, '0, 16'h0000);
		check(reply_reg, freq_ch0);
		freq_ch1 = 16'($urandom);
		q(io_map_pkg::fc_read_holding, 9, 16'h0001, '0, 16'h0000);
		check(reply_reg, freq_ch1);
		q(io_map_pkg::fc_write_holding, 8, 16'h0001, '0, 16'h1234);
		check(reply_exception, 1'b1);
		q(io_map_pkg::fc_write_holding, 10, 16'h0001, '0, 16'h0000);
		q(io_map_pkg::fc_write_holding, 11, 16'h0001, '0, io_map_pkg::count_max);
		@(negedge ref_clk);
		count_pulse = 2'b01;
		@(negedge ref_clk);
		count_pulse = 2'b00;
		q(io_map_pkg::fc_read_holding, 11, 16'h0001, '0, 16'h0000);
		check(reply_reg, 16'h0000);
		q(io_map_pkg::fc_read_holding, 10, 16'h0001, '0, 16'h0000);
		check(reply_reg, 16'h0001);
		q(io_map_pkg::fc_write_holding, 13, 16'h0001, '0, 16'h0003);
		@(negedge ref_clk);
		count_pulse = 2'b10;
		@(negedge ref_clk);
		count_pulse = 2'b00;
		q(io_map_pkg::fc_read_holding, 13, 16'h0001, '0, 16'h0000);
		check(reply_reg, 16'h0004);
		$display("holding test done");
		q(io_map_pkg::fc_read_holding, 112, 16'h0001, '0, 16'h0000);
		exc(io_map_pkg::exc_bad_address);
		q(io_map_pkg::fc_read_holding, 16'h9c4c, 16'h0001, '0, 16'h0000);
		exc(io_map_pkg::exc_bad_address);
		foreach (bad_fn[i]) begin
			q(bad_fn[i], 0, 16'h0001, '0, 16'h0000);
			exc(io_map_pkg::exc_bad_function);
		end
		$display("exception test done");
		stop_test();
	end
endmodule // modbus_io_address_decoder_tb
`default_nettype wire
